// *** design/oms_mode_select.sv ***
// Operating mode capture and decode
//
// Operation
// - Capture straps at reset release, use them
// - Decode mode to ROM, CPU mode, space
// - Expanded minimum modes limit address to 64K
// - Expanded maximum modes reach up to 1M
// - Modes one to four allow external cycles
// - Maximum modes save code page on interrupt
// - Mode selects function of multiplexed pins
// - Latch register low bits mirror straps, read-only
// - Latch bits seven, six one; five-three zero
`timescale 1ns/100ps
`include "oms_regs.svh"
module oms_mode_select #(
   // Synchroniser depth per strap pin
   parameter int SYNC_STAGES = `OMS_SYNC_STAGES
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // Strap pins
   input wire logic i_mode_strap_2,
   input wire logic i_mode_strap_1,
   input wire logic i_mode_strap_0,
   // Decoded mode
   output oms_pkg::oms_cfg_t o_cfg,
   output logic [7:0] o_mode_latch_register,
   output logic o_mode_invalid,
   output logic o_mode_valid
);
   import oms_pkg::*;

   // Capture phases: held in reset, one load cycle, then running
   oms_phase_t phase;
   oms_phase_t next_phase;

   // Synchronised straps, the captured code and its decoded views
   wire logic [2:0] stable;
   logic [2:0] strap_pins;
   logic [2:0] latched;
   logic [2:0] mode_code;
   logic capture_now;
   logic outputs_held;
   oms_cfg_t next_cfg;
   logic next_invalid;
   logic [7:0] next_latch_view;

   // A two-stage chain would compare a flop that may still be settling
   if (SYNC_STAGES < 3) begin : g_depth_check
      $error("oms_mode_select needs at least three sync stages");
   end

   // The port list carries exactly three strap pins
   if (`OMS_STRAP_W != 3) begin : g_width_check
      $error("oms_mode_select is built for three strap pins");
   end

   // Codes zero, five and six have no mode behind them
   function automatic logic mode_unusable(input logic [2:0] m);
      return (m == 3'h0) || (m == 3'h5) || (m == 3'h6);
   endfunction

   function automatic oms_cfg_t decode(input logic [2:0] m);
      oms_cfg_t c;
      c = '0;
      case (m)
         `OMS_MODE_1: begin
            c.expanded = 1'b1;
            c.addr_width = `OMS_ADDR_W_MIN;
         end
         `OMS_MODE_2: begin
            c.expanded = 1'b1;
            c.rom_enable = 1'b1;
            c.addr_width = `OMS_ADDR_W_MIN;
         end
         `OMS_MODE_3: begin
            c.expanded = 1'b1;
            c.cpu_max = 1'b1;
            c.save_code_page = 1'b1;
            c.port6_bus = 1'b1;
            c.addr_width = `OMS_ADDR_W_MAX;
         end
         `OMS_MODE_4: begin
            c.expanded = 1'b1;
            c.rom_enable = 1'b1;
            c.cpu_max = 1'b1;
            c.save_code_page = 1'b1;
            c.port6_bus = 1'b1;
            c.addr_width = `OMS_ADDR_W_MAX;
         end
         `OMS_MODE_7: begin
            c.rom_enable = 1'b1;
            c.addr_width = `OMS_ADDR_W_MIN;
         end
         default: begin
            c = '0;
         end
      endcase
      return c;
   endfunction

   assign strap_pins = {i_mode_strap_2, i_mode_strap_1, i_mode_strap_0};

   // Straps are board levels with no clock of their own: each pin runs
   // through its own chain, and a level counts once the last two agree.
   // No reset here, so the chain tracks the straps while reset is held.
   for (genvar b = 0; b < `OMS_STRAP_W; b++) begin : g_sync
      logic [SYNC_STAGES-1:0] chain;
      logic level;

      always_ff @(posedge i_clk_sys) begin
         chain <= {chain[SYNC_STAGES-2:0], strap_pins[b]};
      end

      always_ff @(posedge i_clk_sys) begin
         if (chain[SYNC_STAGES-1] == chain[SYNC_STAGES-2]) begin
            level <= chain[SYNC_STAGES-1];
         end
      end

      assign stable[b] = level;
   end

   // One load cycle after release, then run until the next reset
   always_comb begin
      next_phase = phase;
      case (phase)
         PH_HELD: begin
            next_phase = PH_LOAD;
         end
         PH_LOAD: begin
            next_phase = PH_RUN;
         end
         PH_RUN: begin
            next_phase = PH_RUN;
         end
         // A lost code falls back to PH_HELD and captures again on the next clock, without a reset
         default: begin
            next_phase = PH_HELD;
         end
      endcase
   end

   // Reset wins over the phase sequence
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         phase <= PH_HELD;
      end else begin
         phase <= next_phase;
      end
   end

   // Capture on the first clock after release, never under reset itself
   assign capture_now = (phase == PH_HELD) && !i_reset;

   // Outputs stay at their reset values (latch view at its reset pattern) until the captured code has landed
   assign outputs_held = i_reset || (phase == PH_HELD);

   // Mode bits sit at the register's reset pattern until the capture
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         latched <= 3'(`OMS_LATCH_RST);
      end else if (capture_now) begin
         latched <= stable;
      end
   end

   // Only reset and capture_now write the code, so later strap changes are lost
   assign mode_code = latched;

   always_comb begin
      next_cfg = decode(mode_code);
   end

   // Invalid codes decode to an all-zero setup; the flag is for test
   always_comb begin
      next_invalid = mode_unusable(mode_code);
   end

   // Fixed top bits over the latched code; there is no write path
   always_comb begin
      next_latch_view = {`OMS_LATCH_HI, `OMS_LATCH_MID, mode_code};
   end

   // Decoded setup: space, ROM, CPU mode, bus access, pin roles
   always_ff @(posedge i_clk_sys) begin
      if (outputs_held) begin
         o_cfg <= '0;
      end else begin
         o_cfg <= next_cfg;
      end
   end

   // Registered so the view changes in step with the other outputs
   always_ff @(posedge i_clk_sys) begin
      if (outputs_held) begin
         o_mode_latch_register <= `OMS_LATCH_RST;
      end else begin
         o_mode_latch_register <= next_latch_view;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (outputs_held) begin
         o_mode_invalid <= 1'b0;
      end else begin
         o_mode_invalid <= next_invalid;
      end
   end

   // Valid marks the cycle from which every output above can be used
   always_ff @(posedge i_clk_sys) begin
      if (outputs_held) begin
         o_mode_valid <= 1'b0;
      end else begin
         o_mode_valid <= 1'b1;
      end
   end
endmodule

// *** design/oms_regs.svh ***
// Constants for the operating mode select block
`ifndef OMS_REGS_SVH
`define OMS_REGS_SVH
`define OMS_STRAP_W 3
`define OMS_MODE_1 3'h1
`define OMS_MODE_2 3'h2
`define OMS_MODE_3 3'h3
`define OMS_MODE_4 3'h4
`define OMS_MODE_7 3'h7
`define OMS_LATCH_RST 8'hc7
`define OMS_LATCH_HI 2'h3
`define OMS_LATCH_MID 3'h0
`define OMS_ADDR_W_MIN 5'h10
`define OMS_ADDR_W_MAX 5'h14
`define OMS_SYNC_STAGES 3
`endif

// *** design/oms_pkg.sv ***
// Types for the operating mode select block
package oms_pkg;
   typedef struct packed {
      logic expanded;
      logic rom_enable;
      logic cpu_max;
      logic save_code_page;
      logic port6_bus;
      logic [4:0] addr_width;
   } oms_cfg_t;

   // Capture sequencing, one-hot
   typedef enum logic [2:0] {
      PH_HELD = 3'h1,
      PH_LOAD = 3'h2,
      PH_RUN = 3'h4
   } oms_phase_t;
endpackage

// *** test/oms_strap_model.sv ***
// Board strapping model driving the three mode pins
`timescale 1ns/100ps
module oms_strap_model (
   // Strap code chosen by the bench, bit 2 first
   input wire logic [2:0] i_code,
   // Mode pins
   output logic [2:0] o_pins
);
   // Straps are plain levels; invalid codes only when a test asks
   assign o_pins = i_code;
endmodule

// *** test/oms_mode_select_monitor.sv ***
// Checker for the operating mode select block
`timescale 1ns/100ps
module oms_mode_select_monitor (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // Strap pins
   input wire logic i_mode_strap_2,
   input wire logic i_mode_strap_1,
   input wire logic i_mode_strap_0,
   // Outputs of the block
   input wire oms_pkg::oms_cfg_t o_cfg,
   input wire logic [7:0] o_mode_latch_register,
   input wire logic o_mode_invalid,
   input wire logic o_mode_valid
);
   import oms_pkg::*;
   wire logic [2:0] m = o_mode_latch_register[2:0];
   wire logic v = o_mode_valid;
   wire oms_cfg_t c = o_cfg;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   sequence s_rel; $fell(i_reset); endsequence
   property p_cap; s_rel |-> ##[1:3] v && m ==
      {i_mode_strap_2, i_mode_strap_1, i_mode_strap_0}; endproperty
   a_cap: assert property (p_cap) else $error("capture");
   property p_keep; v |=> v && $stable(o_mode_latch_register); endproperty
   a_keep: assert property (p_keep) else $error("drift");
   property p_top; o_mode_latch_register[7:3] == 5'h18; endproperty
   a_top: assert property (p_top) else $error("top bits");
   property p_ext; v |-> c.expanded == m inside {[3'h1:3'h4]}; endproperty
   a_ext: assert property (p_ext) else $error("expanded");
   property p_max; v |-> c.cpu_max == m inside {3'h3, 3'h4}; endproperty
   a_max: assert property (p_max) else $error("cpu mode");
   property p_cp; {c.save_code_page, c.port6_bus} == {2{c.cpu_max}};
   endproperty
   a_cp: assert property (p_cp) else $error("code page");
   property p_aw; v && c.expanded |->
      c.addr_width == (c.cpu_max ? 5'h14 : 5'h10); endproperty
   a_aw: assert property (p_aw) else $error("space");
   property p_inv; v |-> o_mode_invalid == m inside {3'h0, 3'h5, 3'h6};
   endproperty
   a_inv: assert property (p_inv) else $error("invalid");
endmodule
bind oms_mode_select oms_mode_select_monitor oms_mode_select_monitor_i (
   .i_clk_sys(i_clk_sys),
   .i_reset(i_reset),
   .i_mode_strap_2(i_mode_strap_2),
   .i_mode_strap_1(i_mode_strap_1),
   .i_mode_strap_0(i_mode_strap_0),
   .o_cfg(o_cfg),
   .o_mode_latch_register(o_mode_latch_register),
   .o_mode_invalid(o_mode_invalid),
   .o_mode_valid(o_mode_valid)
);

// *** test/oms_mode_select_bench.sv ***
// Testbench for the operating mode select block
`timescale 1ns/100ps
module oms_mode_select_bench;
   import oms_pkg::*;
   logic i_clk_sys = 0, i_reset = 1, o_mode_invalid, o_mode_valid;
   wire logic [2:0] pins;
   logic [2:0] code = 3'h1;
   logic [7:0] o_mode_latch_register;
   oms_cfg_t o_cfg;
   int num_errors, cmp_count;
   always #5 i_clk_sys = ~i_clk_sys;
   oms_strap_model oms_strap_model_i (.i_code(code), .o_pins(pins));
   oms_mode_select oms_mode_select_i (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_mode_strap_2(pins[2]),
      .i_mode_strap_1(pins[1]),
      .i_mode_strap_0(pins[0]),
      .o_cfg(o_cfg),
      .o_mode_latch_register(o_mode_latch_register),
      .o_mode_invalid(o_mode_invalid),
      .o_mode_valid(o_mode_valid));
   function logic unusable(logic [2:0] m);
      return m inside {3'h0, 3'h5, 3'h6};
   endfunction
   function oms_cfg_t want(logic [2:0] m);
      logic x;
      x = m inside {3'h3, 3'h4};
      return unusable(m) ? '0 : {m != 3'h7, m inside {3'h2, 3'h4, 3'h7},
         x, x, x, x ? 5'h14 : 5'h10};
   endfunction
   task chk(logic [9:0] s, e);
      cmp_count++;
      if (s !== e) $display("FAIL %0t mismatch %h %h", $time, s, e);
      num_errors += (s !== e);
   endtask
   task print_verdict;
      $display("%0d compares, %0d errors", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Straps flip after capture, so a design that recaptures shows it
   task run(logic [2:0] m);
      @(posedge i_clk_sys) i_reset <= 1;
      code <= m;
      repeat (7) @(posedge i_clk_sys);
      @(posedge i_clk_sys) i_reset <= 0;
      repeat (4) @(posedge i_clk_sys);
      @(posedge i_clk_sys) code <= ~m;
      repeat (5) @(posedge i_clk_sys);
      #1 chk(o_mode_latch_register, {5'h18, m});
      chk(o_cfg, want(m));
      chk({o_mode_valid, o_mode_invalid}, {1'b1, unusable(m)});
      $display("mode %0d test done", m);
   endtask
   initial begin
      void'($urandom(32'h8f95c3a9));
      for (int i = 0; i < 8; i++) run(3'(i));
      repeat (6) run(3'($urandom));
      print_verdict;
   end
   initial begin
      #9000;
      num_errors++;
      print_verdict;
   end
endmodule
